// file: logic/embedded_memory_block.sv
// Embedded memory block: AXI4-Lite registers, input and output register
// groups, CAM write sequencer and encoded or unencoded match reporting.
// Assumes one clock aclk shared with the bus master; global_clear is a pin.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "embedded_memory_block_defines.svh"
module embedded_memory_block
  import embedded_memory_block_pkg::*;
(
  input  logic                aclk,
  input  logic                aresetn,
  input  logic                ce,
  input  logic                global_clear,
  input  logic [`AXI_AW-1:0]  awaddr,
  input  logic                awvalid,
  output logic                awready,
  input  logic [31:0]         wdata,
  input  logic [3:0]          wstrb,
  input  logic                wvalid,
  output logic                wready,
  output logic [1:0]          bresp,
  output logic                bvalid,
  input  logic                bready,
  input  logic [`AXI_AW-1:0]  araddr,
  input  logic                arvalid,
  output logic                arready,
  output logic [31:0]         rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  logic                rready,
  output logic [31:0]         data_out_q,
  output logic [15:0]         match_lines_q,
  output logic                match_phase_q,
  output logic [4:0]          match_addr_q,
  output logic                match_found_q
);
  logic               gclr_meta_q;
  logic               gclr_q;
  logic               aw_full_q;
  logic               w_full_q;
  logic [`AXI_AW-1:0] wa_q;
  logic [31:0]        wd_q;
  logic [3:0]         ws_q;
  logic [31:0]        ctrl_q;
  logic [31:0]        addr_q;
  logic [31:0]        wdat_q;
  logic [31:0]        care_q;
  logic               in_we_q;
  logic               in_rd_q;
  logic               in_srch_q;
  logic [31:0]        in_data_q;
  logic [31:0]        in_care_q;
  logic [4:0]         in_waddr_q;
  logic [4:0]         in_raddr_q;
  wr_state_t          wr_q;
  wr_state_t          wr_d;
  out_state_t         out_q;
  out_state_t         out_d;
  logic               rd_pend_q;
  logic               hit_pend_q;
  logic [15:0]        hi_hold_q;
  logic [31:0]        mem_rdata;
  logic               mem_rd_v;
  logic [31:0]        mem_hit;
  logic               mem_hit_v;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Lowest matching index wins
  function automatic logic [4:0] encode(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      if (v[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  // Bus write side
  wire aw_take   = awvalid & awready;
  wire w_take    = wvalid & wready;
  wire do_write  = aw_full_q & w_full_q & ~bvalid;
  wire aw_full_d = ~do_write & (aw_full_q | aw_take);
  wire w_full_d  = ~do_write & (w_full_q | w_take);
  wire sel_ctrl  = wa_q == `REG_CTRL;
  wire sel_addr  = wa_q == `REG_ADDR;
  wire sel_wdat  = wa_q == `REG_WDATA;
  wire sel_care  = wa_q == `REG_CARE;
  wire sel_cmd   = wa_q == `REG_CMD;
  wire wr_ok     = sel_ctrl | sel_addr | sel_wdat | sel_care | sel_cmd;

  // Bus read side
  wire ar_take  = arvalid & arready;
  wire rvalid_d = ar_take | (rvalid & ~rready);
  wire rd_ok    = (araddr[1:0] == 2'h0) && (araddr <= `REG_MATCH);

  // Control fields
  wire cam     = ctrl_q[`CTRL_CAM];
  wire sp      = ctrl_q[`CTRL_SPORT];
  wire enc     = ctrl_q[`CTRL_ENC];
  wire in_ce   = ctrl_q[`CTRL_IN_CE];
  wire oce     = ctrl_q[`CTRL_OUT_CE];
  wire in_clr  = ctrl_q[`CTRL_IN_CLR] | gclr_q;
  wire out_clr = ctrl_q[`CTRL_OUT_CLR] | gclr_q;

  // Commands
  wire       cmd_go   = do_write & sel_cmd & ws_q[0];
  wire       cmd_we   = cmd_go & wd_q[`CMD_WR];
  wire       cmd_rd   = cmd_go & wd_q[`CMD_RD];
  wire       cmd_srch = cmd_go & wd_q[`CMD_SRCH];
  wire       busy     = in_we_q | (wr_q != WR_IDLE);
  wire       accept   = cmd_go & in_ce & ~busy & ~in_clr;
  wire [4:0] wa_field = addr_q[`ADDR_WA_LSB +: 5];
  wire [4:0] ra_field = sp ? wa_field : addr_q[`ADDR_RA_LSB +: 5];
  wire       dc       = in_care_q != `CARE_ALL;
  wire       mem_we   = (in_we_q & ~cam) | ((wr_q == WR_TWO) & ~dc) | (wr_q == WR_THREE);

  // Output stage
  wire rd_pend_d  = mem_rd_v | (rd_pend_q & ~oce);
  wire hit_pend_d = mem_hit_v | (hit_pend_q & ~(oce & (out_q == OUT_IDLE)));
  wire lo_load    = oce & hit_pend_q & (out_q == OUT_IDLE) & ~enc;
  wire en_load    = oce & hit_pend_q & (out_q == OUT_IDLE) & enc;
  wire hi_load    = oce & (out_q == OUT_HI);

  wire [31:0] status_w = {15'h0000, match_phase_q, 3'h0, match_addr_q, 6'h00,
                          match_found_q, busy};
  wire [31:0] match_w  = {15'h0000, match_phase_q, match_lines_q};
  wire [31:0] rd_word  = (araddr == `REG_CTRL)   ? ctrl_q   :
                         (araddr == `REG_ADDR)   ? addr_q   :
                         (araddr == `REG_WDATA)  ? wdat_q   :
                         (araddr == `REG_CARE)   ? care_q   :
                         (araddr == `REG_STATUS) ? status_w :
                         (araddr == `REG_RDATA)  ? data_out_q :
                         (araddr == `REG_MATCH)  ? match_w  : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gclr_meta_q <= 1'b0;
      gclr_q      <= 1'b0;
    end else if (ce) begin
      gclr_meta_q <= global_clear;
      gclr_q      <= gclr_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      wa_q      <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
    end else if (ce) begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready   <= ~aw_full_d;
      wready    <= ~w_full_d;
      bvalid    <= do_write | (bvalid & ~bready);
      if (do_write) begin
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (aw_take) begin
        wa_q <= awaddr;
      end
      if (w_take) begin
        wd_q <= wdata;
        ws_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      arready <= ~rvalid_d;
      rvalid  <= rvalid_d;
      if (ar_take) begin
        rdata <= rd_ok ? rd_word : 32'h0000_0000;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RESET;
      addr_q <= 32'h0000_0000;
      wdat_q <= 32'h0000_0000;
      care_q <= `CARE_ALL;
    end else if (ce && do_write) begin
      if (sel_ctrl) begin
        ctrl_q <= apply_strb(ctrl_q, wd_q, ws_q) & `CTRL_MASK;
      end
      if (sel_addr) begin
        addr_q <= apply_strb(addr_q, wd_q, ws_q) & `ADDR_MASK;
      end
      if (sel_wdat) begin
        wdat_q <= apply_strb(wdat_q, wd_q, ws_q);
      end
      if (sel_care) begin
        care_q <= apply_strb(care_q, wd_q, ws_q);
      end
    end
  end

  // Input register group
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && in_clr)) begin
      in_we_q    <= 1'b0;
      in_rd_q    <= 1'b0;
      in_srch_q  <= 1'b0;
      in_data_q  <= 32'h0000_0000;
      in_care_q  <= `CARE_ALL;
      in_waddr_q <= 5'h00;
      in_raddr_q <= 5'h00;
    end else if (ce) begin
      in_we_q   <= accept & cmd_we;
      in_rd_q   <= accept & cmd_rd & ~(sp & cmd_we);
      in_srch_q <= accept & cmd_srch & cam & ~cmd_we;
      if (accept) begin
        in_data_q  <= wdat_q;
        in_care_q  <= cam ? care_q : `CARE_ALL;
        in_waddr_q <= wa_field;
        in_raddr_q <= ra_field;
      end
    end
  end

  always_comb begin
    wr_d = wr_q;
    unique case (wr_q)
      WR_IDLE:  wr_d = (in_we_q && cam) ? WR_TWO : WR_IDLE;
      WR_TWO:   wr_d = dc ? WR_THREE : WR_IDLE;
      WR_THREE: wr_d = WR_IDLE;
      default:  wr_d = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && in_clr)) begin
      wr_q <= WR_IDLE;
    end else if (ce) begin
      wr_q <= wr_d;
    end
  end

  cam_store u_store (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .we          (mem_we),
    .waddr       (in_waddr_q),
    .wdata       (in_data_q),
    .wcare       (in_care_q),
    .read_strobe (in_rd_q),
    .raddr       (in_raddr_q),
    .srch        (in_srch_q),
    .key         (in_data_q),
    .rdata_q     (mem_rdata),
    .rd_v_q      (mem_rd_v),
    .hit_q       (mem_hit),
    .hit_v_q     (mem_hit_v)
  );

  always_comb begin
    out_d = out_q;
    unique case (out_q)
      OUT_IDLE: out_d = lo_load ? OUT_HI : OUT_IDLE;
      OUT_HI:   out_d = hi_load ? OUT_IDLE : OUT_HI;
    endcase
  end

  // Output register group
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && out_clr)) begin
      out_q         <= OUT_IDLE;
      rd_pend_q     <= 1'b0;
      hit_pend_q    <= 1'b0;
      hi_hold_q     <= 16'h0000;
      data_out_q    <= 32'h0000_0000;
      match_lines_q <= 16'h0000;
      match_phase_q <= 1'b0;
      match_addr_q  <= 5'h00;
      match_found_q <= 1'b0;
    end else if (ce) begin
      out_q      <= out_d;
      rd_pend_q  <= rd_pend_d;
      hit_pend_q <= hit_pend_d;
      if (oce && rd_pend_q) begin
        data_out_q <= mem_rdata;
      end
      if (lo_load) begin
        hi_hold_q     <= mem_hit[31:16];
        match_lines_q <= mem_hit[15:0];
        match_phase_q <= 1'b0;
      end
      if (hi_load) begin
        match_lines_q <= hi_hold_q;
        match_phase_q <= 1'b1;
      end
      if (en_load) begin
        match_addr_q  <= encode(mem_hit);
        match_found_q <= mem_hit != 32'h0000_0000;
      end
    end
  end

  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  sequence s_wr_start;
    (wr_q == WR_IDLE) && in_we_q && cam;
  endsequence
  sequence s_lo_load;
    lo_load && !out_clr;
  endsequence

  property p_capture;
    disable iff (!aresetn || !ce || in_clr)
    accept && cmd_we |=> in_we_q && (in_data_q == $past(wdat_q))
                         && (in_waddr_q == $past(wa_field));
  endproperty
  a_capture: assert property (p_capture) else $error("input capture wrong");

  property p_out_hold;
    !oce && !out_clr |=> $stable(data_out_q) && $stable(match_lines_q);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved");

  property p_in_hold;
    !in_ce && !in_clr && !busy |=> $stable(in_data_q) && !in_we_q;
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("input moved");

  property p_clear;
    gclr_q |=> (data_out_q == 32'h0000_0000) && !in_we_q && !match_found_q
               && (wr_q == WR_IDLE);
  endproperty
  a_clear: assert property (p_clear) else $error("global clear missed");

  property p_sport;
    disable iff (!aresetn || !ce || in_clr)
    accept && sp |=> (in_raddr_q == in_waddr_q) && !(in_rd_q && in_we_q);
  endproperty
  a_sport: assert property (p_sport) else $error("single port shared wrong");

  property p_search;
    disable iff (!aresetn || !ce || in_clr)
    accept && cmd_srch && cam && !cmd_we |=> in_srch_q ##1 mem_hit_v;
  endproperty
  a_search: assert property (p_search) else $error("search not run");

  property p_wr_two;
    disable iff (!aresetn || !ce || in_clr)
    s_wr_start ##0 !dc |-> !mem_we ##1 mem_we ##1 !busy;
  endproperty
  a_wr_two: assert property (p_wr_two) else $error("two cycle write wrong");

  property p_wr_three;
    disable iff (!aresetn || !ce || in_clr)
    s_wr_start ##0 dc |-> !mem_we ##1 !mem_we ##1 mem_we ##1 !busy;
  endproperty
  a_wr_three: assert property (p_wr_three) else $error("masked write wrong");

  property p_lo;
    s_lo_load |=> (match_lines_q == $past(mem_hit[15:0])) && !match_phase_q;
  endproperty
  a_lo: assert property (p_lo) else $error("low half wrong");

  property p_hi;
    s_lo_load ##1 (oce && !out_clr) |=> match_phase_q
                                        && (match_lines_q == $past(mem_hit[31:16], 2));
  endproperty
  a_hi: assert property (p_hi) else $error("high half wrong");

  property p_enc;
    en_load && !out_clr |=> (match_found_q == ($past(mem_hit) != 32'h0000_0000))
      && (!match_found_q || ((($past(mem_hit) >> match_addr_q) & 32'h0000_0001)
                             != 32'h0000_0000));
  endproperty
  a_enc: assert property (p_enc) else $error("encoded result wrong");
endmodule

// file: logic/embedded_memory_block_defines.svh
// Register map, field positions, reset values and sizes of the memory block.
// Assumes inclusion by bare name from files under logic/.
`ifndef EMBEDDED_MEMORY_BLOCK_DEFINES_SVH
`define EMBEDDED_MEMORY_BLOCK_DEFINES_SVH
`define AXI_AW       8
`define REG_CTRL     8'h00
`define REG_ADDR     8'h04
`define REG_WDATA    8'h08
`define REG_CARE     8'h0C
`define REG_CMD      8'h10
`define REG_STATUS   8'h14
`define REG_RDATA    8'h18
`define REG_MATCH    8'h1C
`define CTRL_CAM     0
`define CTRL_SPORT   1
`define CTRL_ENC     2
`define CTRL_IN_CE   3
`define CTRL_OUT_CE  4
`define CTRL_IN_CLR  5
`define CTRL_OUT_CLR 6
`define CTRL_MASK    32'h0000_007F
`define CTRL_RESET   32'h0000_0018
`define ADDR_WA_LSB  0
`define ADDR_RA_LSB  8
`define ADDR_MASK    32'h0000_1F1F
`define CMD_WR       0
`define CMD_RD       1
`define CMD_SRCH     2
`define CARE_ALL     32'hFFFF_FFFF
`define CAM_PRELOAD  32'h0000_0000
`define CAM_WORDS    32
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// file: logic/embedded_memory_block_pkg.sv
// State types shared by the memory block files.
// Assumes no other package in the build uses these names.
package embedded_memory_block_pkg;
  typedef enum logic [1:0] {WR_IDLE, WR_TWO, WR_THREE} wr_state_t;
  typedef enum logic {OUT_IDLE, OUT_HI} out_state_t;
endpackage

// file: logic/cam_store.sv
// Storage of 32 words with care masks, registered read and parallel match.
// Assumes writes, reads and searches come from the input register group.
`include "embedded_memory_block_defines.svh"
module cam_store
  import embedded_memory_block_pkg::*;
#(
  parameter logic [31:0] PRELOAD = `CAM_PRELOAD
)(
  input  logic        aclk,
  input  logic        aresetn,
  input  logic        ce,
  input  logic        we,
  input  logic [4:0]  waddr,
  input  logic [31:0] wdata,
  input  logic [31:0] wcare,
  input  logic        read_strobe,
  input  logic [4:0]  raddr,
  input  logic        srch,
  input  logic [31:0] key,
  output logic [31:0] rdata_q,
  output logic        rd_v_q,
  output logic [31:0] hit_q,
  output logic        hit_v_q
);
  logic [31:0] word_q [`CAM_WORDS];
  logic [31:0] care_q [`CAM_WORDS];
  logic [31:0] hit_d;

  for (genvar i = 0; i < `CAM_WORDS; i++) begin : g_cmp
    assign hit_d[i] = ((word_q[i] ^ key) & care_q[i]) == 32'h0000_0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < `CAM_WORDS; k++) begin
        word_q[k] <= PRELOAD;
        care_q[k] <= `CARE_ALL;
      end
    end else if (ce && we) begin
      word_q[waddr] <= wdata;
      care_q[waddr] <= wcare;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rd_v_q  <= 1'b0;
      hit_q   <= 32'h0000_0000;
      hit_v_q <= 1'b0;
    end else if (ce) begin
      rd_v_q  <= read_strobe;
      hit_v_q <= srch;
      if (read_strobe) begin
        rdata_q <= word_q[raddr];
      end
      if (srch) begin
        hit_q <= hit_d;
      end
    end
  end
endmodule

// file: dv/fabric_master.sv
// Fabric-side AXI4-Lite master, one write or one read under way at a time.
// Assumes aclk is shared with the block and that the caller starts after reset.
`include "embedded_memory_block_defines.svh"
module fabric_master (
  input  wire logic              aclk,
  output logic [`AXI_AW-1:0]     awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [31:0]            wdata,
  output logic [3:0]             wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic [`AXI_AW-1:0]     araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic              rvalid,
  output logic                   rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [`AXI_AW-1:0] a, input logic [31:0] d, output bit tmo);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1;
      end
    end
    tmo = !done;
  endtask
  task automatic rd(input logic [`AXI_AW-1:0] a, output logic [31:0] q, output bit tmo);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        q = rdata;
        rready <= 1'b0;
        done = 1;
      end
    end
    tmo = !done;
  endtask
endmodule

// file: dv/tb_embedded_memory_block.sv
// Self-checking bench: RAM modes, group enables and clears, CAM search.
// Assumes the block answers over AXI4-Lite on aclk with ce held high.
`include "embedded_memory_block_defines.svh"
module tb_embedded_memory_block;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic chk; logic [33:0] v;} note_t;
  localparam logic [1:0]  OK = `RESP_OKAY;
  localparam logic [31:0] WR = 32'h0000_0001 << `CMD_WR;
  localparam logic [31:0] RD = 32'h0000_0001 << `CMD_RD;
  localparam logic [31:0] SR = 32'h0000_0001 << `CMD_SRCH;
  logic               aclk, aresetn, ce, global_clear, watch;
  logic [`AXI_AW-1:0] awaddr, araddr;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [31:0]        wdata, rdata, data_out_q, d, x, y, z, k;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic [15:0]        match_lines_q;
  logic               match_phase_q, match_found_q;
  logic [4:0]         match_addr_q;
  logic [16:0]        last_ln;
  note_t              rd_q[$];
  logic [1:0]         b_q[$];
  logic [16:0]        ln_q[$];
  int                 bad_count, checks, seed;
  embedded_memory_block embedded_memory_block_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .global_clear(global_clear),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .data_out_q(data_out_q), .match_lines_q(match_lines_q), .match_phase_q(match_phase_q),
    .match_addr_q(match_addr_q), .match_found_q(match_found_q));
  fabric_master fabric_master_i (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic stop();
    bad_count++;
    complete_run();
  endtask
  // Monitor takes the oldest note whenever a result appears
  always @(posedge aclk) begin
    note_t n;
    if (bvalid === 1'b1 && bready === 1'b1 && b_q.size() > 0)
      check("bresp", 34'(bresp), 34'(b_q.pop_front()));
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
      n = rd_q.pop_front();
      if (n.chk) check("rdata", {rresp, rdata}, n.v);
    end
    if (watch && ln_q.size() > 0 && {match_phase_q, match_lines_q} !== last_ln)
      check("lines", 34'({match_phase_q, match_lines_q}), 34'(ln_q.pop_front()));
    last_ln <= {match_phase_q, match_lines_q};
  end
  task automatic wr(input logic [`AXI_AW-1:0] a, input logic [31:0] v, input logic [1:0] r);
    bit t;
    b_q.push_back(r);
    fabric_master_i.wr(a, v, t);
    if (t) stop();
  endtask
  task automatic rd(input logic [`AXI_AW-1:0] a, input logic c, input logic [33:0] e);
    bit t;
    rd_q.push_back({c, e});
    fabric_master_i.rd(a, d, t);
    if (t) stop();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    d = 32'h0000_0001;
    while (d[0] !== 1'b0 && n < 50) begin
      rd(`REG_STATUS, 1'b0, '0);
      n++;
    end
    if (n >= 50) stop();
  endtask
  task automatic cmd(input logic [4:0] wa, input logic [4:0] ra, input logic [31:0] c);
    wr(`REG_ADDR, {19'h0_0000, ra, 3'h0, wa}, OK);
    wr(`REG_CMD, c, OK);
    wait_idle();
  endtask
  task automatic camw(input logic [4:0] wa, input logic [31:0] v, input logic [31:0] care);
    wr(`REG_CARE, care, OK);
    wr(`REG_WDATA, v, OK);
    cmd(wa, 5'h00, WR);
  endtask
  task automatic srch(input logic [31:0] key);
    wr(`REG_WDATA, key, OK);
    cmd(5'h00, 5'h00, SR);
  endtask
  task automatic enc(input logic f, input logic [4:0] a);
    check("found", 34'(match_found_q), 34'(f));
    if (f) check("addr", 34'(match_addr_q), 34'(a));
    rd(`REG_STATUS, 1'b1, {OK, 15'h0000, 1'b0, 3'h0, a, 6'h00, f, 1'b0});
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    stop();
  end
  initial begin
    seed = 32'hf490;
    ce = 1'b1;
    global_clear = 1'b0;
    watch = 1'b0;
    last_ln = '0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL, 1'b1, {OK, `CTRL_RESET});
    rd(`REG_CARE, 1'b1, {OK, `CARE_ALL});
    rd(8'h20, 1'b1, {`RESP_SLVERR, 32'h0000_0000});
    wr(`REG_STATUS, 32'h0000_0000, `RESP_SLVERR);
    x = $random(seed);
    y = $random(seed);
    z = $random(seed);
    wr(`REG_WDATA, x, OK);
    cmd(5'h07, 5'h07, WR);
    cmd(5'h07, 5'h07, RD);
    rd(`REG_RDATA, 1'b1, {OK, x});
    wr(`REG_WDATA, y, OK);
    cmd(5'h08, 5'h08, WR);
    wr(`REG_CTRL, 32'h0000_0008, OK);
    cmd(5'h08, 5'h08, RD);
    rd(`REG_RDATA, 1'b1, {OK, x});
    wr(`REG_CTRL, 32'h0000_0018, OK);
    rd(`REG_RDATA, 1'b1, {OK, y});
    wr(`REG_CTRL, 32'h0000_0038, OK);
    wr(`REG_WDATA, z, OK);
    cmd(5'h07, 5'h07, WR);
    wr(`REG_CTRL, 32'h0000_0018, OK);
    cmd(5'h07, 5'h07, RD);
    rd(`REG_RDATA, 1'b1, {OK, x});
    wr(`REG_CTRL, 32'h0000_0058, OK);
    rd(`REG_RDATA, 1'b1, {OK, 32'h0000_0000});
    wr(`REG_CTRL, 32'h0000_0018, OK);
    cmd(5'h07, 5'h07, RD);
    global_clear <= 1'b1;
    repeat (4) @(posedge aclk);
    global_clear <= 1'b0;
    rd(`REG_RDATA, 1'b1, {OK, 32'h0000_0000});
    wr(`REG_CTRL, 32'h0000_001A, OK);
    wr(`REG_WDATA, z, OK);
    cmd(5'h09, 5'h07, WR);
    cmd(5'h09, 5'h07, RD);
    rd(`REG_RDATA, 1'b1, {OK, z});
    wr(`REG_WDATA, y, OK);
    cmd(5'h09, 5'h07, WR | RD);
    rd(`REG_RDATA, 1'b1, {OK, z});
    cmd(5'h09, 5'h07, RD);
    rd(`REG_RDATA, 1'b1, {OK, y});
    // Input group disabled: command dropped, output unchanged
    wr(`REG_CTRL, 32'h0000_0010, OK);
    cmd(5'h07, 5'h07, RD);
    rd(`REG_RDATA, 1'b1, {OK, y});
    // Encoded CAM, first search matches every preloaded word
    wr(`REG_CTRL, 32'h0000_001D, OK);
    srch(32'h0000_0000);
    enc(1'b1, 5'h00);
    k = $random(seed) | 32'h8000_0000;
    camw(5'h0C, k, `CARE_ALL);
    srch(k);
    enc(1'b1, 5'h0C);
    camw(5'h1F, ~k, `CARE_ALL);
    srch(~k);
    enc(1'b1, 5'h1F);
    srch(k ^ 32'h0000_0001);
    enc(1'b0, 5'h00);
    camw(5'h05, {k[31:16], 16'h0000}, 32'hFFFF_0000);
    srch({k[31:16], ~k[15:0]});
    enc(1'b1, 5'h05);
    // Unencoded CAM with a duplicate word
    wr(`REG_CTRL, 32'h0000_0019, OK);
    z = k ^ 32'h4000_0000;
    camw(5'h03, z, `CARE_ALL);
    camw(5'h14, z, `CARE_ALL);
    ln_q.push_back({1'b0, 16'h0008});
    ln_q.push_back({1'b1, 16'h0010});
    watch = 1'b1;
    srch(z);
    rd(`REG_MATCH, 1'b1, {OK, 15'h0000, 1'b1, 16'h0010});
    repeat (4) @(posedge aclk);
    check("lines_left", 34'(ln_q.size()), '0);
    complete_run();
  end
endmodule
